// >>> fido_cmd_logic.v
// Serial command logic: power-down release, identification reads,
// unique number read and one-time-programmable security row program.
// Assumes the host drives chip select, serial clock and serial input
// slowly against i_ref_clk; all three are oversampled here.
//
// Behaviour
// - Opcode ABh alone in a frame starts leaving power-down.
// - No instruction accepted until recovery time has elapsed.
// - Release and identification opcodes ignored while a cycle runs.
// - ABh plus three dummy bytes shifts first device code MSB first.
// - Legacy read repeats first device code until chip select rises.
// - 9Fh returns maker code, first device code, second device code.
// - Standard read cycles those three bytes until chip select rises.
// - Address bit 0 picks order of first two maker/device bytes.
// - A1h, three address bytes, one dummy, then 16-byte number.
// - Unique number repeats while chip select stays low.
// - Unique number start byte taken from address bits 3 to 0.
// - Row needs upper address bytes zero; FFh is control byte.
// - Data bytes programmable only while lock bit reads one.
// - Programmed zero bits never return to one.
// - Row program needs write enable latch set.
// - Row program starts only on chip select rise, else discarded.
// - Bytes past the last supplied byte stay unchanged.
// - Write-in-progress held during program, only status read served.
// - Write enable latch cleared before program completes.
// - Row program ignored while another cycle runs.
// - In power-down only ABh is recognised.
// - Status read returns write-in-progress flag.
`timescale 1ns/10ps
`default_nettype none
`include "fido_cmd_regs.vh"

module fido_cmd_logic #(
  parameter [7:0]   MAKER_CODE_1  = 8'h5A,   // Arbitrary value
  parameter [7:0]   MAKER_CODE_2  = 8'h3C,   // Arbitrary value
  parameter [7:0]   DEVICE_CODE_1 = 8'h21,   // Arbitrary value
  parameter [7:0]   DEVICE_CODE_2 = 8'h42,   // Arbitrary value
  parameter [127:0] UNIQUE_NUMBER = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
  parameter [23:0]  RECOVERY_CYC  = `FIDO_RECOVERY_CYC,
  parameter [23:0]  PROGRAM_CYC   = `FIDO_PROGRAM_CYC
) (
  input  wire i_ref_clk,
  input  wire i_rst_n,
  input  wire i_spi_cs_n,
  input  wire i_spi_sck,
  input  wire i_spi_si,
  input  wire i_ext_busy,
  output reg  o_spi_so,
  output reg  o_spi_so_oe_n,
  output reg  o_write_in_progress,
  output reg  o_write_enable_latch,
  output reg  o_power_down,
  output reg  o_row_locked
);
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE    = 4'b0001;
  localparam [3:0] ST_PD      = 4'b0010;
  localparam [3:0] ST_RECOVER = 4'b0100;
  localparam [3:0] ST_PROG    = 4'b1000;

  reg  [2:0]  cs_sync_r, sck_sync_r, si_sync_r, bit_cnt_r, out_bit_r;
  reg         cs_lvl_r, sck_lvl_r, ignore_r, out_act_r, lock_open_r, wel_r;
  reg  [7:0]  in_sr_r, opcode_r, out_sr_r, prog_addr_r;
  reg  [8:0]  byte_cnt_r, data_cnt_r, prog_i_r, prog_cnt_r;
  reg  [23:0] addr_r, timer_r;
  reg  [3:0]  out_idx_r, state_r;
  reg  [1:0]  phase_r;
  reg  [7:0]  row_mem [0:255];
  reg  [7:0]  load_buf [0:255];
  integer     k;
  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_sync_r  <= 3'b111;
      sck_sync_r <= 3'b000;
      si_sync_r  <= 3'b000;
      cs_lvl_r   <= 1'b1;
      sck_lvl_r  <= 1'b0;
    end else begin
      cs_sync_r  <= {cs_sync_r[1:0], i_spi_cs_n};
      sck_sync_r <= {sck_sync_r[1:0], i_spi_sck};
      si_sync_r  <= {si_sync_r[1:0], i_spi_si};
      if (cs_sync_r[1] == cs_sync_r[2])
        cs_lvl_r <= cs_sync_r[2];
      if (sck_sync_r[1] == sck_sync_r[2])
        sck_lvl_r <= sck_sync_r[2];
    end
  end
  // Edges of the agreed levels; clock edges count only inside a frame
  wire cs_agree  = (cs_sync_r[1] == cs_sync_r[2]);
  wire sck_agree = (sck_sync_r[1] == sck_sync_r[2]);
  wire cs_fall   = cs_agree & ~cs_sync_r[2] & cs_lvl_r;
  wire cs_rise   = cs_agree & cs_sync_r[2] & ~cs_lvl_r;
  wire sck_rise  = sck_agree & sck_sync_r[2] & ~sck_lvl_r & ~cs_lvl_r;
  wire sck_fall  = sck_agree & ~sck_sync_r[2] & sck_lvl_r & ~cs_lvl_r;
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  wire       busy      = state_r[3] | i_ext_busy;
  wire [7:0] new_byte  = {in_sr_r[6:0], si_sync_r[2]};
  wire       byte_done = sck_rise & (bit_cnt_r == 3'd7);
  // Header length per opcode; zero means no output phase
  function [8:0] hdr_len;
    input [7:0] op;
    begin
      case (op)
        `FIDO_OP_RELEASE_PD:  hdr_len = `FIDO_HDR_LEGACY;
        `FIDO_OP_MAKER_IDENT: hdr_len = `FIDO_HDR_MAKER;
        `FIDO_OP_UNIQUE_READ: hdr_len = `FIDO_HDR_UNIQUE;
        `FIDO_OP_STD_IDENT:   hdr_len = `FIDO_HDR_SHORT;
        `FIDO_OP_STATUS_READ: hdr_len = `FIDO_HDR_SHORT;
        default:              hdr_len = 9'h000;
      endcase
    end
  endfunction
  wire op_ignored = state_r[2] |
                    (state_r[1] & (new_byte != `FIDO_OP_RELEASE_PD)) |
                    (busy & (new_byte != `FIDO_OP_STATUS_READ));
  // Next byte to shift out
  reg  [7:0] next_byte;
  wire [3:0] uid_k = addr_r[3:0] + out_idx_r;
  always @* begin
    next_byte = 8'h00;
    case (opcode_r)
      `FIDO_OP_RELEASE_PD: next_byte = DEVICE_CODE_1;
      `FIDO_OP_STD_IDENT:
        next_byte = (phase_r == 2'd0) ? MAKER_CODE_1 :
                    (phase_r == 2'd1) ? DEVICE_CODE_1 : DEVICE_CODE_2;
      // Order chosen by address bit 0
      `FIDO_OP_MAKER_IDENT:
        next_byte = (phase_r == 2'd2) ? MAKER_CODE_2 :
                    ((phase_r == 2'd0) ^ addr_r[0]) ? MAKER_CODE_1 : DEVICE_CODE_1;
      `FIDO_OP_UNIQUE_READ: next_byte = UNIQUE_NUMBER[{uid_k, 3'b000} +: 8];
      `FIDO_OP_STATUS_READ: begin
        next_byte[`FIDO_STAT_WIP_BIT] = busy;
        next_byte[`FIDO_STAT_WEL_BIT] = wel_r;
      end
      default: next_byte = 8'h00;
    endcase
  end
  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  // Bytes are counted per frame; output starts after the header
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_sr_r       <= 8'h00;
      bit_cnt_r     <= 3'd0;
      byte_cnt_r    <= 9'h000;
      opcode_r      <= 8'h00;
      addr_r        <= 24'h00_0000;
      ignore_r      <= 1'b1;
      out_act_r     <= 1'b0;
      out_sr_r      <= 8'h00;
      out_bit_r     <= 3'd0;
      out_idx_r     <= 4'h0;
      phase_r       <= 2'd0;
      data_cnt_r    <= 9'h000;
      o_spi_so      <= 1'b0;
      o_spi_so_oe_n <= 1'b1;
    end else begin
      if (cs_fall) begin
        bit_cnt_r  <= 3'd0;
        byte_cnt_r <= 9'h000;
        ignore_r   <= 1'b0;
        out_act_r  <= 1'b0;
        out_bit_r  <= 3'd0;
        out_idx_r  <= 4'h0;
        phase_r    <= 2'd0;
        data_cnt_r <= 9'h000;
      end
      // Output released with chip select high
      if (cs_rise) begin
        o_spi_so_oe_n <= 1'b1;
        out_act_r     <= 1'b0;
      end
      if (sck_rise) begin
        in_sr_r   <= new_byte;
        bit_cnt_r <= bit_cnt_r + 3'd1;
      end
      if (byte_done) begin
        if (byte_cnt_r != 9'h1FF)
          byte_cnt_r <= byte_cnt_r + 9'h001;
        if (byte_cnt_r == 9'h000) begin
          opcode_r <= new_byte;
          ignore_r <= op_ignored;
          if (!op_ignored && hdr_len(new_byte) == `FIDO_HDR_SHORT)
            out_act_r <= 1'b1;
        end else begin
          if (byte_cnt_r <= 9'h003)
            addr_r <= {addr_r[15:0], new_byte};
          if (!ignore_r && (byte_cnt_r + 9'h001) == hdr_len(opcode_r))
            out_act_r <= 1'b1;
          // Count data bytes, at most one row
          if (!ignore_r && opcode_r == `FIDO_OP_ROW_PROGRAM &&
              byte_cnt_r >= `FIDO_HDR_PROGRAM && data_cnt_r < `FIDO_ROW_MAX_BYTES)
            data_cnt_r <= data_cnt_r + 9'h001;
        end
      end
      // Shift out MSB first on falling clock
      if (sck_fall && out_act_r && !cs_rise) begin
        o_spi_so_oe_n <= 1'b0;
        out_bit_r     <= out_bit_r + 3'd1;
        if (out_bit_r == 3'd0) begin
          o_spi_so  <= next_byte[7];
          out_sr_r  <= {next_byte[6:0], 1'b0};
          out_idx_r <= out_idx_r + 4'h1;
          phase_r   <= (phase_r == 2'd2) ? 2'd0 : phase_r + 2'd1;
        end else begin
          o_spi_so <= out_sr_r[7];
          out_sr_r <= {out_sr_r[6:0], 1'b0};
        end
      end
    end
  end

  // Program data capture; buffer frozen while a program runs
  wire buf_we = byte_done & ~ignore_r & (opcode_r == `FIDO_OP_ROW_PROGRAM) &
                (byte_cnt_r >= `FIDO_HDR_PROGRAM) & (data_cnt_r < `FIDO_ROW_MAX_BYTES);
  always @(posedge i_ref_clk) begin
    if (buf_we)
      load_buf[data_cnt_r[7:0]] <= new_byte;
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire frame_ok  = ~ignore_r & (bit_cnt_r == 3'd0) & (byte_cnt_r != 9'h000);
  wire short_cmd = frame_ok & (byte_cnt_r == 9'h001);
  wire prog_go   = frame_ok & (opcode_r == `FIDO_OP_ROW_PROGRAM) &
                   (byte_cnt_r > `FIDO_HDR_PROGRAM) & wel_r &
                   (addr_r[23:8] == 16'h0000);
  wire [8:0] wr_addr = {1'b0, prog_addr_r} + prog_i_r;
  wire       wr_step = state_r[3] & (prog_i_r < prog_cnt_r) & ~wr_addr[8];
  // Command sequencer; commands act only on chip select rise
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r     <= ST_IDLE;
      timer_r     <= 24'h00_0000;
      prog_i_r    <= 9'h000;
      prog_cnt_r  <= 9'h000;
      prog_addr_r <= 8'h00;
      lock_open_r <= 1'b1;
      wel_r       <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cs_rise && short_cmd && !i_ext_busy &&
              opcode_r == `FIDO_OP_WRITE_ENABLE)
            wel_r <= 1'b1;
          if (cs_rise && short_cmd && !i_ext_busy && opcode_r == `FIDO_OP_DEEP_PD)
            state_r <= ST_PD;
          // Launch only on chip select rise when idle
          else if (cs_rise && prog_go && !i_ext_busy) begin
            state_r     <= ST_PROG;
            timer_r     <= PROGRAM_CYC;
            prog_i_r    <= 9'h000;
            prog_cnt_r  <= data_cnt_r;
            prog_addr_r <= addr_r[7:0];
            lock_open_r <= row_mem[`FIDO_ROW_CTRL_ADDR][`FIDO_ROW_LOCK_BIT];
            wel_r       <= 1'b0;
          end
        end
        ST_PD: begin
          if (cs_rise && frame_ok && opcode_r == `FIDO_OP_RELEASE_PD) begin
            state_r <= ST_RECOVER;
            timer_r <= RECOVERY_CYC;
          end
        end
        ST_RECOVER: begin
          timer_r <= timer_r - 24'h00_0001;
          if (timer_r <= 24'h00_0001)
            state_r <= ST_IDLE;
        end
        ST_PROG: begin
          // Self-timed cycle ends on timer either way
          timer_r <= timer_r - 24'h00_0001;
          if (wr_step)
            prog_i_r <= prog_i_r + 9'h001;
          if (timer_r <= 24'h00_0001)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Security row storage
  // ----------------------------------------------------------------
  // Factory-erased content; models non-volatile cells, so no reset
  initial begin
    for (k = 0; k < 256; k = k + 1)
      row_mem[k] = `FIDO_ROW_ERASED;
  end
  // Locked row takes no data bytes
  wire row_we = wr_step & (lock_open_r | (wr_addr[7:0] == `FIDO_ROW_CTRL_ADDR));
  always @(posedge i_ref_clk) begin
    if (row_we)
      row_mem[wr_addr[7:0]] <= row_mem[wr_addr[7:0]] & load_buf[prog_i_r[7:0]];
  end
  // ----------------------------------------------------------------
  // Registered status outputs
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_write_in_progress  <= 1'b0;
      o_write_enable_latch <= 1'b0;
      o_power_down         <= 1'b0;
      o_row_locked         <= 1'b0;
    end else begin
      o_write_in_progress  <= state_r[3];
      o_write_enable_latch <= wel_r;
      o_power_down         <= state_r[1] | state_r[2];
      o_row_locked         <= ~row_mem[`FIDO_ROW_CTRL_ADDR][`FIDO_ROW_LOCK_BIT];
    end
  end

endmodule // fido_cmd_logic

`default_nettype wire

// >>> fido_cmd_regs.vh
// Constants for the identification and security-row command logic.
// Assumes inclusion by the single design file; definitions only.
`ifndef FIDO_CMD_REGS_VH
`define FIDO_CMD_REGS_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FIDO_OP_RELEASE_PD       8'hAB
`define FIDO_OP_STD_IDENT        8'h9F
`define FIDO_OP_MAKER_IDENT      8'h90
`define FIDO_OP_UNIQUE_READ      8'hA1
`define FIDO_OP_ROW_PROGRAM      8'hB1
`define FIDO_OP_WRITE_ENABLE     8'h06
`define FIDO_OP_STATUS_READ      8'h05
`define FIDO_OP_DEEP_PD          8'hB9

// ----------------------------------------------------------------
// Header lengths in bytes before output or program data starts
// ----------------------------------------------------------------
`define FIDO_HDR_LEGACY          9'h004
`define FIDO_HDR_MAKER           9'h004
`define FIDO_HDR_UNIQUE          9'h005
`define FIDO_HDR_SHORT           9'h001
`define FIDO_HDR_PROGRAM         9'h004

// ----------------------------------------------------------------
// Status byte fields and security row layout
// ----------------------------------------------------------------
`define FIDO_STAT_WIP_BIT        0
`define FIDO_STAT_WEL_BIT        1
`define FIDO_ROW_CTRL_ADDR       8'hFF
`define FIDO_ROW_LOCK_BIT        0
`define FIDO_ROW_ERASED          8'hFF
`define FIDO_ROW_MAX_BYTES       9'h100

// ----------------------------------------------------------------
// Timing in reference clocks of 100 ns
// ----------------------------------------------------------------
// Recovery 3000 ns, row program 2 ms; sized to the timer width
`define FIDO_RECOVERY_CYC        24'h00_001E
`define FIDO_PROGRAM_CYC         24'h00_4E20

`endif

// >>> fido_host.sv
// Host serial controller model: frames of whole bytes, mode 0 clock.
// Assumes a free-running reference clock; pins change at its falling edge.
`timescale 1ns/10ps
`default_nettype none

module fido_host (
  input  wire logic i_ref_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe_n,
  output var  logic o_cs_n,
  output var  logic o_sck,
  output var  logic o_si
);
  logic [7:0] tx [0:15];
  logic [7:0] rx [0:15];
  logic       drove;

  // Idle pins; clock stands still outside frames
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    drove = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame
  // ----------------------------------------------------------------
  // whole bytes MSB first
  task automatic xfer(input int n);
    int i;
    int b;
    drove = 1'b0;
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    for (i = 0; i < n; i++) begin
      for (b = 7; b >= 0; b--) begin
        o_si = tx[i][b];
        repeat (4) @(negedge i_ref_clk);
        o_sck = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        // Late in the high phase, long after the launching fall
        // Released line reads as the inverse of its last level
        rx[i][b] = (i_so_oe_n === 1'b0) ? i_so : ~i_so;
        if (i_so_oe_n === 1'b0) drove = 1'b1;
        o_sck = 1'b0;
      end
    end
    repeat (4) @(negedge i_ref_clk);
    // select raised, held high between frames
    o_cs_n = 1'b1;
    // Released data line flips so no stale level is mistaken for data
    o_si = ~o_si;
    repeat (8) @(negedge i_ref_clk);
  endtask
endmodule // fido_host

`default_nettype wire

// >>> fido_properties.sv
// Checker for the identification and security-row command logic.
// Assumes it is bound to the logic's top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module fido_properties #(
  parameter logic [23:0] RECOVERY_CYC = 24'h00_001E,
  parameter logic [23:0] PROGRAM_CYC  = 24'h00_4E20
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sck,
  input wire logic i_spi_si,
  input wire logic i_ext_busy,
  input wire logic o_spi_so,
  input wire logic o_spi_so_oe_n,
  input wire logic o_write_in_progress,
  input wire logic o_write_enable_latch,
  input wire logic o_power_down,
  input wire logic o_row_locked
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [23:0] wip_cnt_r;
  logic [7:0]  cs_cnt_r;

  // Busy length and time since select rose; only the select count saturates, at FFh
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wip_cnt_r <= 24'h00_0000;
      cs_cnt_r  <= 8'h00;
    end else begin
      wip_cnt_r <= o_write_in_progress ? wip_cnt_r + 24'h00_0001 : 24'h00_0000;
      cs_cnt_r  <= !i_spi_cs_n ? 8'h00 : (cs_cnt_r == 8'hFF) ? cs_cnt_r : cs_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_oe_idle; i_spi_cs_n [*5] |-> o_spi_so_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
  property p_oe_frame; $fell(o_spi_so_oe_n) |-> !i_spi_cs_n; endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("output started outside frame");
  property p_prog_len;
    $fell(o_write_in_progress) |-> wip_cnt_r >= PROGRAM_CYC - 1 && wip_cnt_r <= PROGRAM_CYC + 1;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program cycle length wrong");
  property p_prog_cs; $rose(o_write_in_progress) |-> i_spi_cs_n; endproperty
  a_prog_cs: assert property (p_prog_cs) else $error("program began inside frame");
  property p_prog_wel;
    $rose(o_write_in_progress) |-> $past(o_write_enable_latch, 1) ||
      $past(o_write_enable_latch, 2) || $past(o_write_enable_latch, 3);
  endproperty
  a_prog_wel: assert property (p_prog_wel) else $error("program without enable latch");
  property p_wel_clear; $rose(o_write_in_progress) |-> ##[0:2] !o_write_enable_latch; endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("enable latch kept in program");
  property p_busy;
    i_ext_busy [*6] |=> !$rose(o_write_in_progress) && !$rose(o_write_enable_latch);
  endproperty
  a_busy: assert property (p_busy) else $error("command taken while busy");
  property p_recovery;
    $fell(o_power_down) |-> cs_cnt_r >= RECOVERY_CYC && cs_cnt_r <= RECOVERY_CYC + 12;
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery time wrong");
  property p_pd_quiet; o_power_down && !o_write_enable_latch |=> !o_write_enable_latch; endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("command taken in power down");
  property p_lock_keep; !$fell(o_row_locked); endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock bit returned to one");
endmodule // fido_properties

`default_nettype wire

// >>> test_fido_cmd_logic.sv
// Self-checking bench for the identification and security-row logic.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/10ps
`default_nettype none

module test_fido_cmd_logic;
  localparam logic [7:0]   M1 = 8'h5A;
  localparam logic [7:0]   M2 = 8'h3C;
  localparam logic [7:0]   D1 = 8'h21;
  localparam logic [7:0]   D2 = 8'h42;
  localparam logic [127:0] UNUM = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [23:0]  REC_CYC = 24'h00_0005;
  localparam logic [23:0]  PROG_CYC = 24'h00_012C;
  // Answer byte cycles, first byte in the lowest bits
  localparam logic [23:0]  STD = {D2, D1, M1};
  localparam logic [23:0]  MK0 = {M2, D1, M1};
  localparam logic [23:0]  MK1 = {M2, M1, D1};
  logic clk, rst_n, ext_busy, a;
  logic [23:0] exp3;
  wire  cs_n, sck, si, so, so_oe_n, write_in_progress, write_enable_latch, pd, locked;
  int   fail_count, n_tests, cyc, k;

  fido_cmd_logic #(.MAKER_CODE_1(M1), .MAKER_CODE_2(M2), .DEVICE_CODE_1(D1),
    .DEVICE_CODE_2(D2), .UNIQUE_NUMBER(UNUM), .RECOVERY_CYC(REC_CYC),
    .PROGRAM_CYC(PROG_CYC)) fido_cmd_logic_i (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_spi_cs_n(cs_n), .i_spi_sck(sck), .i_spi_si(si), .i_ext_busy(ext_busy),
    .o_spi_so(so), .o_spi_so_oe_n(so_oe_n), .o_write_in_progress(write_in_progress),
    .o_write_enable_latch(write_enable_latch), .o_power_down(pd), .o_row_locked(locked));
  fido_host fido_host_i (.i_ref_clk(clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n),
    .o_sck(sck), .o_si(si));

  // Clock and hang guard; a whole run needs far fewer cycles
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Header bytes from the top of hdr, then nrx answer bytes clocked out
  task run(input logic [47:0] hdr, input int nh, input int nrx);
    int i;
    for (i = 0; i < 16; i++) fido_host_i.tx[i] = (i < nh) ? hdr[47 - 8 * i -: 8] : 8'h00;
    fido_host_i.xfer(nh + nrx);
  endtask
  // Bounded wait for busy (sel 0) or power-down (sel 1) to reach v
  task wait_lvl(input int sel, input logic v);
    int j;
    for (j = 0; j < 1000; j++) begin
      if (((sel == 0) ? write_in_progress : pd) === v) break;
      @(negedge clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ext_busy = 1'b0;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    check("oe_n_reset", {7'h00, so_oe_n}, 8'h01);
    repeat (4) @(negedge clk);
    run(48'h9F00_0000_0000, 1, 7);
    for (k = 0; k < 7; k++)
      check("std_id", fido_host_i.rx[1 + k], STD[8 * (k % 3) +: 8]);
    // Both byte orders of the maker/device read
    for (k = 0; k < 8; k++) begin
      a = (k > 3);
      exp3 = a ? MK1 : MK0;
      if (k % 4 == 0) run({8'h90, 16'h0000, 7'h00, a, 16'h0000}, 4, 4);
      check("maker_id", fido_host_i.rx[4 + k % 4], exp3[8 * (k % 4 % 3) +: 8]);
    end
    run(48'hAB00_0000_0000, 4, 2);
    for (k = 0; k < 2; k++) check("legacy_id", fido_host_i.rx[4 + k], D1);
    // Start at byte 14 so the read wraps past byte 15
    run(48'hA100_000E_0000, 5, 3);
    for (k = 0; k < 3; k++)
      check("unique", fido_host_i.rx[5 + k], UNUM[8 * ((14 + k) % 16) +: 8]);
    run(48'h0600_0000_0000, 1, 0);
    run(48'h0500_0000_0000, 1, 1);
    check("status_wel", fido_host_i.rx[1], 8'h02);
    // Nonzero upper address byte is discarded
    run(48'hB101_0010_0F00, 5, 0);
    check("wip_badaddr", {7'h00, write_in_progress}, 8'h00);
    run(48'hB100_0010_0F00, 5, 0);
    repeat (4) @(negedge clk);
    check("wip_prog", {7'h00, write_in_progress}, 8'h01);
    check("wel_prog", {7'h00, write_enable_latch}, 8'h00);
    run(48'h0500_0000_0000, 1, 1);
    check("status_busy", fido_host_i.rx[1], 8'h01);
    run(48'h9F00_0000_0000, 1, 1);
    check("id_in_prog", {7'h00, fido_host_i.drove}, 8'h00);
    wait_lvl(0, 1'b0);
    check("wip_done", {7'h00, write_in_progress}, 8'h00);
    // Lock attempt without the enable latch does nothing
    run(48'hB100_00FF_FE00, 5, 0);
    check("wip_nowel", {7'h00, write_in_progress}, 8'h00);
    check("unlocked", {7'h00, locked}, 8'h00);
    for (k = 0; k < 2; k++) begin
      run(48'h0600_0000_0000, 1, 0);
      run((k == 0) ? 48'hB100_00FF_FE00 : 48'hB100_00FF_0100, 5, 0);
      repeat (4) @(negedge clk);
      check("wip_lock", {7'h00, write_in_progress}, 8'h01);
      wait_lvl(0, 1'b0);
      check("wip_lock_done", {7'h00, write_in_progress}, 8'h00);
      check("locked", {7'h00, locked}, 8'h01);
    end
    ext_busy = 1'b1;
    run(48'h0600_0000_0000, 1, 0);
    check("wel_ext_busy", {7'h00, write_enable_latch}, 8'h00);
    run(48'h0500_0000_0000, 1, 1);
    check("status_ext", fido_host_i.rx[1], 8'h01);
    run(48'hAB00_0000_0000, 4, 1);
    check("id_ext_busy", {7'h00, fido_host_i.drove}, 8'h00);
    ext_busy = 1'b0;
    run(48'hB900_0000_0000, 1, 0);
    check("pd_enter", {7'h00, pd}, 8'h01);
    run(48'h0500_0000_0000, 1, 1);
    check("status_pd", {7'h00, fido_host_i.drove}, 8'h00);
    run(48'h0600_0000_0000, 1, 0);
    check("wel_pd", {7'h00, write_enable_latch}, 8'h00);
    run(48'hAB00_0000_0000, 1, 0);
    wait_lvl(1, 1'b0);
    check("pd_release", {7'h00, pd}, 8'h00);
    run(48'h0500_0000_0000, 1, 1);
    check("status_after", fido_host_i.rx[1], 8'h00);
    results();
  end
endmodule // test_fido_cmd_logic

bind fido_cmd_logic fido_properties #(.RECOVERY_CYC(RECOVERY_CYC), .PROGRAM_CYC(PROGRAM_CYC))
  fido_properties_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_spi_cs_n(i_spi_cs_n),
  .i_spi_sck(i_spi_sck), .i_spi_si(i_spi_si), .i_ext_busy(i_ext_busy), .o_spi_so(o_spi_so),
  .o_spi_so_oe_n(o_spi_so_oe_n), .o_write_in_progress(o_write_in_progress),
  .o_write_enable_latch(o_write_enable_latch), .o_power_down(o_power_down),
  .o_row_locked(o_row_locked));

`default_nettype wire
